// ### call_jump_move_pkg.sv
package call_jump_move_pkg;
    // direct addresses of the registers this slice keeps itself
    localparam logic [7:0] ADDR_ACC = 8'hE0;
    localparam logic [7:0] ADDR_SP = 8'h81;
    localparam logic [7:0] ADDR_PTR_LO = 8'h82;
    localparam logic [7:0] ADDR_PTR_HI = 8'h83;
    localparam logic [7:0] ADDR_HIGH_LATCH = 8'hA0;
    localparam logic [3:0] BIT_AREA_BASE = 4'h2;
    // reset values
    localparam logic [7:0] SP_RESET = 8'h07;
    localparam logic [7:0] HIGH_RESET = 8'hFF;
    localparam logic [15:0] PC_RESET = 16'h0000;
    // opcodes
    localparam logic [7:0] OPC_BRANCH = 8'h02;
    localparam logic [7:0] OPC_CALL = 8'h12;
    localparam logic [7:0] OPC_LOAD_PTR = 8'h90;
    localparam logic [7:0] OPC_C_TO_BIT = 8'h92;
    localparam logic [7:0] OPC_BIT_TO_C = 8'hA2;
    localparam logic [7:0] OPC_CODE_PTR = 8'h93;
    localparam logic [7:0] OPC_CODE_PC = 8'h83;
    // external strobe width, a least time rounded up
    localparam int CLK_NS = 20;
    localparam int STROBE_NS = 40;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0] STROBE_LAST = 2'(STROBE_CYC - 1);
    typedef enum logic [3:0] {
        ST_FETCH, ST_OP, ST_B2, ST_B3, ST_EX, ST_IND, ST_SRC, ST_DST,
        ST_DIND, ST_BIT, ST_PUSH, ST_CODE, ST_XRI, ST_XA, ST_XL, ST_XS
    } state_t;
    typedef enum logic [3:0] {
        C_MOVB, C_BITC, C_BITW, C_CALL, C_BRANCH, C_PTR,
        C_CODED, C_CODEP, C_XRD, C_XWR, C_BAD
    } cls_t;
    typedef enum logic [2:0] {K_NONE, K_A, K_REG, K_DIR, K_IND, K_IMM} opnd_t;
endpackage

// ### call_jump_move_executor.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - long_subroutine_call pushes program_counter+3 low byte first, stack index rises two
// - then program_counter takes byte two as high, byte three as low
// - long_branch loads program_counter from bytes two and three, no flags
// - opcode 02h is the three-byte long_branch, high byte first
// - byte_copy copies source to destination, nothing else changes
// - byte_copy direct accumulator into accumulator is an invalid encoding
// - bit move copies source bit into destination, nothing else changes
// - bit moves only between carry and a directly addressable bit
// - data_pointer load: byte two high, byte three low, no flags
// - code_byte_load reads code at accumulator plus data_pointer or program_counter
// - program_counter base is already advanced; data_pointer base stays unchanged
// - code address add is a full 16-bit add with carry, no flags
// - external_data_transfer moves one byte between accumulator and external memory
// - indirect form drives bank pointer byte multiplexed on the low port
// - pointer form drives high byte on high port, low byte multiplexed
// - high port latch keeps its value while the high port shows the pointer
module call_jump_move_executor
    import call_jump_move_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [7:0] codeData,
    output logic [15:0] codeAddr,
    input wire logic [7:0] ramRdata,
    output logic [7:0] ramAddr,
    output logic [7:0] ramWdata,
    output logic ramWe,
    input wire logic [1:0] bankSel,
    input wire logic [7:0] lowIn,
    output logic [7:0] lowOut,
    output logic lowOe_n,
    output logic [7:0] highOut,
    output logic addrLatch,
    output logic readStrobe_n,
    output logic writeStrobe_n,
    output logic invalidOp,
    output logic [7:0] accValue,
    output logic [15:0] ptrValue,
    output logic [7:0] stackTop,
    output logic [15:0] pcValue,
    output logic carryFlag,
    output logic [7:0] portHighLatch
);
    typedef struct packed {
        state_t st;
        cls_t cls;
        opnd_t srcK;
        opnd_t dstK;
        logic [1:0] len;
        logic [7:0] opc;
        logic [7:0] b2;
        logic [7:0] b3;
        logic [7:0] val;
        logic [7:0] addrLo;
        logic [1:0] cnt;
        logic [15:0] pc;
        logic [7:0] sp;
        logic [7:0] acc;
        logic [15:0] dataPtr;
        logic cy;
        logic [7:0] highLatch;
        logic [15:0] codeAddr;
        logic [7:0] ramAddr;
        logic [7:0] ramWdata;
        logic ramWe;
        logic [7:0] lowOut;
        logic lowOe_n;
        logic [7:0] highOut;
        logic ale;
        logic rd_n;
        logic wr_n;
        logic badOp;
    } core_t;

    typedef struct packed {
        cls_t cls;
        opnd_t srcK;
        opnd_t dstK;
        logic [1:0] len;
    } dec_t;

    core_t s_r;
    core_t s_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // opcode decode; anything outside this slice falls to the invalid class
    function automatic dec_t decode(input logic [7:0] o);
        dec_t d;
        d = '{C_MOVB, K_NONE, K_NONE, 2'd1};
        casez (o)
            8'b1110_1???: d = '{C_MOVB, K_REG, K_A, 2'd1};
            8'b1110_0101: d = '{C_MOVB, K_DIR, K_A, 2'd2};
            8'b1110_011?: d = '{C_MOVB, K_IND, K_A, 2'd1};
            8'b0111_0100: d = '{C_MOVB, K_IMM, K_A, 2'd2};
            8'b1111_1???: d = '{C_MOVB, K_A, K_REG, 2'd1};
            8'b1010_1???: d = '{C_MOVB, K_DIR, K_REG, 2'd2};
            8'b0111_1???: d = '{C_MOVB, K_IMM, K_REG, 2'd2};
            8'b1111_0101: d = '{C_MOVB, K_A, K_DIR, 2'd2};
            8'b1000_1???: d = '{C_MOVB, K_REG, K_DIR, 2'd2};
            8'b1000_0101: d = '{C_MOVB, K_DIR, K_DIR, 2'd3};
            8'b1000_011?: d = '{C_MOVB, K_IND, K_DIR, 2'd2};
            8'b0111_0101: d = '{C_MOVB, K_IMM, K_DIR, 2'd3};
            8'b1111_011?: d = '{C_MOVB, K_A, K_IND, 2'd1};
            8'b1010_011?: d = '{C_MOVB, K_DIR, K_IND, 2'd2};
            8'b0111_011?: d = '{C_MOVB, K_IMM, K_IND, 2'd2};
            OPC_BIT_TO_C: d.cls = C_BITC;
            OPC_C_TO_BIT: d.cls = C_BITW;
            OPC_CALL: d.cls = C_CALL;
            OPC_BRANCH: d.cls = C_BRANCH;
            OPC_LOAD_PTR: d.cls = C_PTR;
            OPC_CODE_PTR: d.cls = C_CODED;
            OPC_CODE_PC: d.cls = C_CODEP;
            8'b1110_00?0, 8'b1110_0011: d.cls = C_XRD;
            8'b1111_00?0, 8'b1111_0011: d.cls = C_XWR;
            default: d.cls = C_BAD;
        endcase
        if (d.cls inside {C_BITC, C_BITW}) begin
            d.len = 2'd2;
        end
        if (d.cls inside {C_CALL, C_BRANCH, C_PTR}) begin
            d.len = 2'd3;
        end
        return d;
    endfunction

    // direct address view: own registers first, everything else from ram port
    function automatic logic [7:0] dirView(input core_t s, input logic [7:0] a,
                                           input logic [7:0] rv);
        unique case (a)
            ADDR_ACC: return s.acc;
            ADDR_SP: return s.sp;
            ADDR_PTR_LO: return s.dataPtr[7:0];
            ADDR_PTR_HI: return s.dataPtr[15:8];
            ADDR_HIGH_LATCH: return s.highLatch;
            default: return rv;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // operand addresses shared by several states
    logic [7:0] regAddr;
    logic [7:0] indAddr;
    logic [7:0] srcDir;
    logic [7:0] dstDir;
    logic [7:0] immVal;
    logic [7:0] bitByte;
    logic badAcc;
    dec_t dec;

    assign regAddr = {3'b000, bankSel, s_r.opc[2:0]};
    assign indAddr = {3'b000, bankSel, 2'b00, s_r.opc[0]};
    assign srcDir = s_r.b2;
    // only the direct-to-direct copy carries its destination in byte three
    assign dstDir = (s_r.srcK == K_DIR) ? s_r.b3 : s_r.b2;
    assign immVal = (s_r.dstK == K_DIR) ? s_r.b3 : s_r.b2;
    // low bit addresses live in the bit area, high ones in 8-aligned registers
    assign bitByte = s_r.b2[7] ? {s_r.b2[7:3], 3'b000} : {BIT_AREA_BASE, s_r.b2[6:3]};
    assign badAcc = s_r.cls == C_MOVB && s_r.srcK == K_DIR && s_r.dstK == K_A
        && s_r.b2 == ADDR_ACC;
    assign dec = decode(codeData);

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic; direct writes are funnelled through one port at the end
    always_comb begin
        logic wrDir;
        logic [7:0] wrAddr;
        logic [7:0] wrVal;
        logic [7:0] bv;
        wrDir = 1'b0;
        wrAddr = dstDir;
        wrVal = s_r.val;
        bv = dirView(s_r, bitByte, ramRdata);
        s_nxt = s_r;
        s_nxt.ramWe = 1'b0;
        s_nxt.badOp = 1'b0;
        s_nxt.ale = 1'b0;
        unique case (s_r.st)
            ST_FETCH: begin
                s_nxt.codeAddr = s_r.pc;
                s_nxt.st = ST_OP;
            end
            ST_OP: begin
                s_nxt.opc = codeData;
                s_nxt.cls = dec.cls;
                s_nxt.srcK = dec.srcK;
                s_nxt.dstK = dec.dstK;
                s_nxt.len = dec.len;
                s_nxt.pc = s_r.pc + 16'h0001;
                s_nxt.codeAddr = s_r.pc + 16'h0001;
                s_nxt.st = (dec.len == 2'd1) ? ST_EX : ST_B2;
            end
            ST_B2: begin
                s_nxt.b2 = codeData;
                s_nxt.pc = s_r.pc + 16'h0001;
                s_nxt.codeAddr = s_r.pc + 16'h0001;
                s_nxt.st = (s_r.len == 2'd3) ? ST_B3 : ST_EX;
            end
            ST_B3: begin
                s_nxt.b3 = codeData;
                s_nxt.pc = s_r.pc + 16'h0001;
                s_nxt.st = ST_EX;
            end
            ST_EX: begin
                s_nxt.st = ST_FETCH;
                unique case (s_r.cls)
                    C_MOVB: begin
                        if (badAcc) begin
                            s_nxt.badOp = 1'b1;
                        end else begin
                            unique case (s_r.srcK)
                                K_A: begin
                                    s_nxt.val = s_r.acc;
                                    s_nxt.st = ST_DST;
                                end
                                K_IMM: begin
                                    s_nxt.val = immVal;
                                    s_nxt.st = ST_DST;
                                end
                                K_REG: begin
                                    s_nxt.ramAddr = regAddr;
                                    s_nxt.st = ST_SRC;
                                end
                                K_DIR: begin
                                    s_nxt.ramAddr = srcDir;
                                    s_nxt.st = ST_SRC;
                                end
                                K_IND: begin
                                    s_nxt.ramAddr = indAddr;
                                    s_nxt.st = ST_IND;
                                end
                                K_NONE: s_nxt.st = ST_FETCH;
                            endcase
                        end
                    end
                    C_BITC, C_BITW: begin
                        s_nxt.ramAddr = bitByte;
                        s_nxt.st = ST_BIT;
                    end
                    C_CALL: begin
                        s_nxt.sp = s_r.sp + 8'h01;
                        s_nxt.ramAddr = s_r.sp + 8'h01;
                        s_nxt.ramWdata = s_r.pc[7:0];
                        s_nxt.ramWe = 1'b1;
                        s_nxt.st = ST_PUSH;
                    end
                    C_BRANCH: s_nxt.pc = {s_r.b2, s_r.b3};
                    C_PTR: s_nxt.dataPtr = {s_r.b2, s_r.b3};
                    C_CODED: begin
                        s_nxt.codeAddr = s_r.dataPtr + {8'h00, s_r.acc};
                        s_nxt.st = ST_CODE;
                    end
                    C_CODEP: begin
                        s_nxt.codeAddr = s_r.pc + {8'h00, s_r.acc};
                        s_nxt.st = ST_CODE;
                    end
                    C_XRD, C_XWR: begin
                        if (s_r.opc[1]) begin
                            s_nxt.ramAddr = indAddr;
                            s_nxt.st = ST_XRI;
                        end else begin
                            s_nxt.addrLo = s_r.dataPtr[7:0];
                            s_nxt.highOut = s_r.dataPtr[15:8];
                            s_nxt.st = ST_XA;
                        end
                    end
                    C_BAD: s_nxt.badOp = 1'b1;
                endcase
            end
            ST_IND: begin
                s_nxt.ramAddr = ramRdata;
                s_nxt.st = ST_SRC;
            end
            ST_SRC: begin
                s_nxt.val = (s_r.srcK == K_DIR) ? dirView(s_r, srcDir, ramRdata) : ramRdata;
                s_nxt.st = ST_DST;
            end
            ST_DST: begin
                s_nxt.st = ST_FETCH;
                unique case (s_r.dstK)
                    K_A: s_nxt.acc = s_r.val;
                    K_REG: begin
                        s_nxt.ramAddr = regAddr;
                        s_nxt.ramWdata = s_r.val;
                        s_nxt.ramWe = 1'b1;
                    end
                    K_DIR: wrDir = 1'b1;
                    K_IND: begin
                        s_nxt.ramAddr = indAddr;
                        s_nxt.st = ST_DIND;
                    end
                    K_NONE, K_IMM: s_nxt.st = ST_FETCH;
                endcase
            end
            ST_DIND: begin
                s_nxt.ramAddr = ramRdata;
                s_nxt.ramWdata = s_r.val;
                s_nxt.ramWe = 1'b1;
                s_nxt.st = ST_FETCH;
            end
            ST_BIT: begin
                // read-modify-write touches only the addressed bit
                if (s_r.cls == C_BITC) begin
                    s_nxt.cy = bv[s_r.b2[2:0]];
                end else begin
                    bv[s_r.b2[2:0]] = s_r.cy;
                    wrDir = 1'b1;
                    wrAddr = bitByte;
                    wrVal = bv;
                end
                s_nxt.st = ST_FETCH;
            end
            ST_PUSH: begin
                s_nxt.sp = s_r.sp + 8'h01;
                s_nxt.ramAddr = s_r.sp + 8'h01;
                s_nxt.ramWdata = s_r.pc[15:8];
                s_nxt.ramWe = 1'b1;
                s_nxt.pc = {s_r.b2, s_r.b3};
                s_nxt.st = ST_FETCH;
            end
            ST_CODE: begin
                s_nxt.acc = codeData;
                s_nxt.st = ST_FETCH;
            end
            ST_XRI: begin
                s_nxt.addrLo = ramRdata;
                s_nxt.st = ST_XA;
            end
            ST_XA: begin
                s_nxt.lowOut = s_r.addrLo;
                s_nxt.lowOe_n = 1'b0;
                s_nxt.ale = 1'b1;
                s_nxt.st = ST_XL;
            end
            ST_XL: begin
                // address stays on the port for a cycle after the latch pulse falls,
                // so the memory never sees data while it still latches the address
                if (!s_r.ale) begin
                    s_nxt.cnt = STROBE_LAST;
                    if (s_r.cls == C_XWR) begin
                        s_nxt.lowOut = s_r.acc;
                        s_nxt.wr_n = 1'b0;
                    end else begin
                        s_nxt.lowOe_n = 1'b1;
                        s_nxt.rd_n = 1'b0;
                    end
                    s_nxt.st = ST_XS;
                end
            end
            ST_XS: begin
                if (s_r.cnt == 2'd0) begin
                    if (s_r.cls == C_XRD) begin
                        s_nxt.acc = lowIn;
                    end
                    s_nxt.rd_n = 1'b1;
                    s_nxt.wr_n = 1'b1;
                    s_nxt.lowOe_n = 1'b1;
                    s_nxt.highOut = s_r.highLatch;
                    s_nxt.st = ST_FETCH;
                end else begin
                    s_nxt.cnt = s_r.cnt - 2'd1;
                end
            end
        endcase
        // direct-address writes: own registers or the ram port
        if (wrDir) begin
            unique case (wrAddr)
                ADDR_ACC: s_nxt.acc = wrVal;
                ADDR_SP: s_nxt.sp = wrVal;
                ADDR_PTR_LO: s_nxt.dataPtr[7:0] = wrVal;
                ADDR_PTR_HI: s_nxt.dataPtr[15:8] = wrVal;
                ADDR_HIGH_LATCH: begin
                    s_nxt.highLatch = wrVal;
                    s_nxt.highOut = wrVal;
                end
                default: begin
                    s_nxt.ramAddr = wrAddr;
                    s_nxt.ramWdata = wrVal;
                    s_nxt.ramWe = 1'b1;
                end
            endcase
        end
    end

    // state register; ports idle released, strobes inactive
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
            s_r.st <= ST_FETCH;
            s_r.pc <= PC_RESET;
            s_r.sp <= SP_RESET;
            s_r.highLatch <= HIGH_RESET;
            s_r.highOut <= HIGH_RESET;
            s_r.lowOe_n <= 1'b1;
            s_r.rd_n <= 1'b1;
            s_r.wr_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign codeAddr = s_r.codeAddr;
    assign ramAddr = s_r.ramAddr;
    assign ramWdata = s_r.ramWdata;
    assign ramWe = s_r.ramWe;
    assign lowOut = s_r.lowOut;
    assign lowOe_n = s_r.lowOe_n;
    assign highOut = s_r.highOut;
    assign addrLatch = s_r.ale;
    assign readStrobe_n = s_r.rd_n;
    assign writeStrobe_n = s_r.wr_n;
    assign invalidOp = s_r.badOp;
    assign accValue = s_r.acc;
    assign ptrValue = s_r.dataPtr;
    assign stackTop = s_r.sp;
    assign pcValue = s_r.pc;
    assign carryFlag = s_r.cy;
    assign portHighLatch = s_r.highLatch;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    a_call_push_low: assert property (s_r.st == ST_EX && s_r.cls == C_CALL |=>
        ramWe && ramWdata == $past(s_r.pc[7:0]) && stackTop == $past(s_r.sp) + 8'h01 ##1
        ramWe && stackTop == $past(s_r.sp, 2) + 8'h02)
        else $error("call push order or stack index wrong");
    a_call_target: assert property (s_r.st == ST_PUSH |=>
        pcValue == {$past(s_r.b2), $past(s_r.b3)})
        else $error("call target wrong");
    a_branch_load: assert property (s_r.st == ST_EX && s_r.opc == OPC_BRANCH |=>
        pcValue == {$past(s_r.b2), $past(s_r.b3)} && $stable(carryFlag))
        else $error("long branch target wrong");
    a_branch_decode: assert property (s_r.st == ST_OP && codeData == OPC_BRANCH |=>
        s_r.cls == C_BRANCH && s_r.st == ST_B2 ##1 s_r.st == ST_B3)
        else $error("long branch not three bytes");
    a_bad_acc: assert property (s_r.st == ST_EX && badAcc |=> invalidOp
        && $stable(accValue) && s_r.st == ST_FETCH)
        else $error("accumulator self copy accepted");
    a_bit_only: assert property (s_r.st == ST_BIT && s_r.cls == C_BITC |=>
        $stable(accValue) && !ramWe)
        else $error("bit to carry touched a byte");
    a_ptr_load: assert property (s_r.st == ST_EX && s_r.cls == C_PTR |=>
        ptrValue == {$past(s_r.b2), $past(s_r.b3)} && $stable(carryFlag))
        else $error("pointer load wrong");
    a_code_addr: assert property (s_r.st == ST_EX && s_r.cls == C_CODED |=>
        codeAddr == $past(ptrValue) + {8'h00, $past(accValue)} && $stable(ptrValue))
        else $error("code lookup address wrong");
    a_high_latch: assert property (s_r.st inside {ST_XA, ST_XL, ST_XS} |=>
        $stable(portHighLatch))
        else $error("high port latch changed");
    a_ptr_high: assert property (!readStrobe_n && s_r.opc[1] == 1'b0 |->
        highOut == ptrValue[15:8])
        else $error("high port not showing pointer");
    a_latch_first: assert property ($fell(readStrobe_n) || $fell(writeStrobe_n) |->
        $past(addrLatch, 2) && readStrobe_n != writeStrobe_n)
        else $error("strobe without address latch");

    c_call: cover property (s_r.st == ST_PUSH);
    c_ext_read: cover property ($rose(readStrobe_n));
    c_ext_write: cover property ($rose(writeStrobe_n));
    c_code_pc: cover property (s_r.st == ST_CODE && s_r.cls == C_CODEP);
endmodule
`default_nettype wire

// ### ext_data_memory.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// far-side data memory on the multiplexed port, 64K bytes, no wait states
module ext_data_memory (
    input wire logic clk_sys,
    input wire logic addrLatch,
    input wire logic [7:0] pinLevel,
    input wire logic [7:0] highOut,
    input wire logic readStrobe_n,
    input wire logic writeStrobe_n,
    output logic memOe,
    output logic [7:0] memData
);
    logic [7:0] mem [0:65535];
    logic [15:0] addrHeld;
    // both halves are caught at the pulse, since the low pins turn to data afterwards
    always @(posedge clk_sys) begin
        if (addrLatch === 1'b1) begin
            addrHeld <= {highOut, pinLevel};
        end
        if (writeStrobe_n === 1'b0) begin
            mem[addrHeld] <= pinLevel;
        end
    end
    // drive the pins only inside the read strobe
    assign memOe = (readStrobe_n === 1'b0);
    assign memData = mem[addrHeld];
endmodule
`default_nettype wire

// ### tb_call_jump_move_executor.sv
`timescale 1ns/1ps
`default_nettype none
module tb_call_jump_move_executor;
    import call_jump_move_pkg::*;
    logic clk_sys, nrst, ramWe, lowOe_n, addrLatch, readStrobe_n, writeStrobe_n;
    logic invalidOp, carryFlag, memOe;
    logic [1:0] bankSel;
    logic [7:0] codeData, ramRdata, ramAddr, ramWdata, lowIn, lowOut, highOut, accValue;
    logic [7:0] stackTop, portHighLatch, memData, lastPin, highSeen;
    logic [15:0] codeAddr, ptrValue, pcValue, wp, spinAt;
    logic [7:0] code [0:65535];
    logic [7:0] ram [0:255];
    int nErrors = 0;
    int checked = 0;
    int nInvalid = 0;
    ////////////////////////////////////////////////////////////////////////////
    call_jump_move_executor dut (.clk_sys(clk_sys), .nrst(nrst), .codeData(codeData),
        .codeAddr(codeAddr), .ramRdata(ramRdata), .ramAddr(ramAddr), .ramWdata(ramWdata),
        .ramWe(ramWe), .bankSel(bankSel), .lowIn(lowIn), .lowOut(lowOut), .lowOe_n(lowOe_n),
        .highOut(highOut), .addrLatch(addrLatch), .readStrobe_n(readStrobe_n),
        .writeStrobe_n(writeStrobe_n), .invalidOp(invalidOp), .accValue(accValue),
        .ptrValue(ptrValue), .stackTop(stackTop), .pcValue(pcValue),
        .carryFlag(carryFlag), .portHighLatch(portHighLatch));
    ext_data_memory xmem (.clk_sys(clk_sys), .addrLatch(addrLatch), .pinLevel(lowIn),
        .highOut(highOut), .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n),
        .memOe(memOe), .memData(memData));
    // released pins float to the inverse of the last level, so stale data never matches
    assign lowIn = (lowOe_n === 1'b0) ? lowOut : (memOe ? memData : ~lastPin);
    assign codeData = code[codeAddr];
    assign ramRdata = ram[ramAddr];
    always #10 clk_sys = ~clk_sys;
    // internal ram, pin history and watchers of the pulses
    always @(posedge clk_sys) begin
        lastPin <= lowIn;
        if (ramWe === 1'b1) ram[ramAddr] <= ramWdata;
        if (addrLatch === 1'b1) highSeen <= highOut;
        if (invalidOp === 1'b1) nInvalid++;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            nErrors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run;
        if (nErrors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic emit(input logic [7:0] b);
        code[wp] = b;
        wp = wp + 16'h0001;
    endtask
    // park on a jump-to-self, then free the previous one by a single byte so the
    // core never sees half a patched target
    task automatic run;
        int n;
        code[wp] = 8'h02;
        code[wp + 16'h0001] = wp[15:8];
        code[wp + 16'h0002] = wp[7:0];
        @(negedge clk_sys);
        code[spinAt + 16'h0002] = spinAt[7:0] + 8'h03;
        spinAt = wp;
        wp = wp + 16'h0003;
        for (n = 0; n < 400 && codeAddr !== spinAt + 16'h0002; n++) @(posedge clk_sys);
        if (n >= 400) begin
            nErrors++;
            complete_run();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic jump_and_call;
        emit(8'h02); emit(8'h01); emit(8'h23);
        wp = 16'h0123;
        emit(8'h12); emit(8'h12); emit(8'h34);
        wp = 16'h1234;
        run();
        check("stack low", {8'h00, ram[8]}, 16'h0026);
        check("call target page", {8'h00, pcValue[15:8]}, 16'h0012);
        check("stack high", {8'h00, ram[9]}, 16'h0001);
        check("stack top", {8'h00, stackTop}, 16'h0009);
    endtask
    task automatic byte_moves;
        emit(8'h74); emit(8'hC5); emit(8'hF5); emit(8'h30);
        emit(8'h85); emit(8'h30); emit(8'h31); emit(8'hE5); emit(8'hE0);
        run();
        check("copied byte", {8'h00, ram[8'h31]}, 16'h00C5);
        check("acc kept", {8'h00, accValue}, 16'h00C5);
        check("invalid pulses", nInvalid[15:0], 16'h0001);
    endtask
    task automatic bit_moves;
        emit(8'hA2); emit(8'h00); emit(8'h92); emit(8'h0F); emit(8'h92); emit(8'hE1);
        run();
        check("carry", {15'h0000, carryFlag}, 16'h0001);
        check("bit byte", {8'h00, ram[8'h21]}, 16'h0080);
        check("acc bit", {8'h00, accValue}, 16'h00C7);
    endtask
    task automatic external_moves;
        emit(8'h75); emit(8'hA0); emit(8'h12); emit(8'h90); emit(8'h56); emit(8'h34);
        emit(8'h78); emit(8'h34); emit(8'hF2); emit(8'h74); emit(8'h66); emit(8'hF0);
        emit(8'h74); emit(8'h00); emit(8'hE0);
        run();
        check("pointer read", {8'h00, accValue}, 16'h0066);
        check("high drivers", {8'h00, highSeen}, 16'h0056);
        check("high latch", {8'h00, portHighLatch}, 16'h0012);
        check("pointer", ptrValue, 16'h5634);
        emit(8'hE2);
        run();
        check("indirect read", {8'h00, accValue}, 16'h00C7);
        check("latch high", {8'h00, highSeen}, 16'h0012);
    endtask
    task automatic code_lookups;
        code[16'h1110] = 8'hA5;
        emit(8'h90); emit(8'h10); emit(8'hF0); emit(8'h74); emit(8'h20); emit(8'h93);
        run();
        check("table by pointer", {8'h00, accValue}, 16'h00A5);
        check("pointer kept", ptrValue, 16'h10F0);
        code[wp + 16'h00A6] = 8'h3C;
        emit(8'h83);
        run();
        check("table by counter", {8'h00, accValue}, 16'h003C);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        nrst = 1'b0;
        bankSel = 2'h2;
        lastPin = 8'h00;
        ram[8'h20] = 8'h01;
        ram[8'h21] = 8'h00;
        code[0] = 8'h02; code[1] = 8'h00; code[2] = 8'h00;
        spinAt = 16'h0000;
        wp = 16'h0003;
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        jump_and_call();
        byte_moves();
        bit_moves();
        external_moves();
        code_lookups();
        complete_run();
    end
endmodule
`default_nettype wire
